// ---- inc/cdrc_pkg.sv ----
// Package for the clock and data recovery acquisition and loop control block
package cdrc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_EDGE_BW = 8'h10;
	localparam logic [7:0] ADDR_SLEW_SLICE = 8'h13;
	localparam logic [7:0] ADDR_SAMPLE_PHASE = 8'h14;
	localparam logic [7:0] ADDR_SLICE_LEVEL = 8'h15;
	localparam logic [7:0] ADDR_TRIM_READBACK = 8'h73;
	// Field positions
	localparam int BW_LSB = 0;
	localparam int EDGE_LSB = 3;
	localparam int SLEW_LSB = 0;
	localparam int AUTO_SLICE_BIT = 2;
	localparam int PHASE_LSB = 0;
	localparam int WIDE_BIT = 7;
	// Reset values
	localparam logic [2:0] BW_RESET = 3'h4;
	localparam logic [1:0] EDGE_RESET = 2'h0;
	localparam logic [1:0] SLEW_RESET = 2'h2;
	localparam logic AUTO_SLICE_RESET = 1'b1;
	localparam logic [3:0] PHASE_RESET = 4'h0;
	localparam logic [7:0] SLICE_RESET = 8'h00;
	// Edge choices
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	// Slice code meaning
	localparam logic [6:0] SLICE_OFF = 7'h00;
	localparam logic [6:0] SLICE_ZERO = 7'h40;
	// Frequency error thresholds in ppm
	localparam logic [15:0] PPM_COARSE = 16'd1000;
	localparam logic [15:0] PPM_FINE = 16'd250;
	// Oscillator tuning word and steps
	localparam logic [15:0] OSC_MIN = 16'h0000;
	localparam logic [15:0] OSC_MAX = 16'hffff;
	localparam logic [15:0] STEP_INIT = 16'h1000;
	localparam logic [15:0] STEP_MIN = 16'h0001;
	localparam logic [2:0] DIV_MIN_LOG = 3'h0;
	localparam logic [2:0] DIV_MAX_LOG = 3'h7;

	// Acquisition states
	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_OCTAVE = 2'b01,
		ST_TUNE = 2'b10,
		ST_LOCKED = 2'b11
	} cdrc_state_t;

	// Configuration carried to the loop hardware
	typedef struct packed {
		logic [2:0] bw_scale;
		logic [1:0] edge_choice;
		logic [1:0] slew;
		logic auto_slice;
		logic [3:0] phase_shift;
		logic wide_slice;
		logic [6:0] slice_code;
	} cdrc_cfg_t;

	// Oscillator and divider control
	typedef struct packed {
		logic [15:0] osc_word;
		logic [2:0] div_log;
		logic freq_loop_en;
	} cdrc_osc_t;
endpackage : cdrc_pkg

// ---- rtl/cdrc_ctrl.sv ----
// Acquisition state machine, lock and signal-loss flags, configuration registers
//
// Operation
// - Frequency error above 1000 ppm raises loss_of_lock_flag and restarts acquisition.
// - Acquisition starts at lowest digital_osc setting and divide ratio one.
// - Sampling faster than data doubles divide ratio; slower raises digital_osc.
// - Oscillator steps shrink near target; within 250 ppm clears loss_of_lock_flag.
// - After lock the frequency loop is off; phase and delay loops track.
// - Normal range code 0 off, 1 is -15 mV, 64 zero, 127 +14.75 mV.
// - Bit seven widens slice range sixfold, to plus or minus 100 mV.
// - Factory trimmed offset reads back as 7 bits, 0.24 mV per step.
// - One binary phase detector feeds both delay and phase loops.
// - phase_edge_choice 1 selects rising edges, 2 falling edges only.
// - delay_loop_slew resets to 2; tracked jitter is (1+value)/4 UI.
// - sampling_instant_shift is signed, 1/32 UI per step, quarter UI range.
// - loop_bandwidth_scale resets to 4; bandwidth scales by value over four.
// - signal_loss_flag sets below threshold, clears only at twice threshold.
`timescale 1ns/1ps
module cdrc_ctrl
	import cdrc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,

	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,

	// Frequency detector
	input wire logic freq_valid,
	input wire logic samp_faster,
	input wire logic [15:0] freq_err_ppm,

	// Phase detector
	input wire logic pd_early,
	input wire logic pd_late,
	input wire logic pd_rise,
	input wire logic pd_fall,

	// Signal level detector
	input wire logic level_below_thr,
	input wire logic level_above_2thr,
	input wire logic [6:0] trim_offset,

	// Loop controls
	output cdrc_cfg_t cfg,
	output cdrc_osc_t osc,
	output logic pd_up,
	output logic pd_dn,
	output logic loss_of_lock_flag,
	output logic signal_loss_flag
);
	// Acquisition state
	cdrc_state_t state_r, state_nxt;
	logic [15:0] osc_r, osc_nxt;
	logic [15:0] step_r, step_nxt;
	logic [2:0] div_r, div_nxt;
	logic lol_r, lol_nxt;

	// Signal-loss flag and configuration registers
	logic los_r;
	logic [7:0] edge_bw_r, slew_r, phase_r, slice_r;

	// Derived control terms
	logic [15:0] osc_room;
	logic [15:0] osc_up_sat, osc_dn_sat, step_half;
	logic err_big, err_fine;
	logic lol_set;
	logic edge_ok;

	// Register decode
	wire wr_edge_bw = reg_wr && (reg_addr == ADDR_EDGE_BW);
	wire wr_slew = reg_wr && (reg_addr == ADDR_SLEW_SLICE);
	wire wr_phase = reg_wr && (reg_addr == ADDR_SAMPLE_PHASE);
	wire wr_slice = reg_wr && (reg_addr == ADDR_SLICE_LEVEL);
	// No write strobe for the trim readback: writes there are dropped

	// Next register values; bits outside the fields are never stored
	wire [7:0] edge_bw_nxt = {3'h0, reg_wdata[4:0]};
	wire [7:0] slew_nxt = {5'h0, reg_wdata[2:0]};
	wire [7:0] phase_nxt = {4'h0, reg_wdata[3:0]};

	// Edge choice and bandwidth scale hold until rewritten
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			edge_bw_r <= {3'h0, EDGE_RESET, BW_RESET};
		else if (wr_edge_bw)
			edge_bw_r <= edge_bw_nxt;
	end

	// Slew and adaptive slice enable; the enable resets on so slicing adapts
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			slew_r <= {5'h0, AUTO_SLICE_RESET, SLEW_RESET};
		else if (wr_slew)
			slew_r <= slew_nxt;
	end

	// Sampling phase shift, kept as the raw signed field
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			phase_r <= {4'h0, PHASE_RESET};
		else if (wr_phase)
			phase_r <= phase_nxt;
	end

	// Slice level uses all eight bits, so nothing is masked here
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			slice_r <= SLICE_RESET;
		else if (wr_slice)
			slice_r <= reg_wdata;
	end

	// Read decode; unmapped offsets select nothing
	wire rd_edge_bw = (reg_addr == ADDR_EDGE_BW);
	wire rd_slew = (reg_addr == ADDR_SLEW_SLICE);
	wire rd_phase = (reg_addr == ADDR_SAMPLE_PHASE);
	wire rd_slice = (reg_addr == ADDR_SLICE_LEVEL);
	wire rd_trim = (reg_addr == ADDR_TRIM_READBACK);
	// The trim value is wired through, not latched, so it always reads current
	wire [7:0] trim_word = {1'b0, trim_offset};

	// Read select as an AND-OR tree, so an unmapped offset reads zero
	assign reg_rdata = ({8{rd_edge_bw}} & edge_bw_r) |
		({8{rd_slew}} & slew_r) |
		({8{rd_phase}} & phase_r) |
		({8{rd_slice}} & slice_r) |
		({8{rd_trim}} & trim_word);

	// Fields out to the analog loops; scaling is done in the DAC and filter
	assign cfg.bw_scale = edge_bw_r[BW_LSB +: 3];
	assign cfg.edge_choice = edge_bw_r[EDGE_LSB +: 2];
	// Slew and phase stay raw; the analog side decodes the signed shift
	assign cfg.slew = slew_r[SLEW_LSB +: 2];
	assign cfg.auto_slice = slew_r[AUTO_SLICE_BIT];
	assign cfg.phase_shift = phase_r[PHASE_LSB +: 4];
	// Range bit and code go out together; the DAC applies the sixfold range
	assign cfg.wide_slice = slice_r[WIDE_BIT];
	// Code zero turns slicing off; 64 is the zero-offset midpoint of the DAC
	assign cfg.slice_code = slice_r[6:0];

	// Edge filter: one detector, both loops share its votes
	wire pass_rise = (cfg.edge_choice == EDGE_RISE);
	wire pass_fall = (cfg.edge_choice == EDGE_FALL);
	// Both edges count otherwise; duty-cycle distortion then opens a dead band,
	// which is why the single-edge settings exist
	assign edge_ok = pass_rise ? pd_rise : pass_fall ? pd_fall : (pd_rise | pd_fall);
	assign pd_up = pd_late && edge_ok;
	assign pd_dn = pd_early && edge_ok;

	// Frequency error classes
	assign err_big = freq_valid && (freq_err_ppm > PPM_COARSE);
	assign err_fine = freq_valid && (freq_err_ppm <= PPM_FINE);
	assign lol_set = (state_r == ST_LOCKED) && err_big;

	// Oscillator steps saturate at both ends of the tuning range; a wrap
	// would throw the search to the far end and cost a full restart
	assign osc_room = OSC_MAX - osc_r;
	assign osc_up_sat = (osc_room < step_r) ? OSC_MAX : osc_r + step_r;
	assign osc_dn_sat = (osc_r < step_r) ? OSC_MIN : osc_r - step_r;
	// Halving on each overshoot down to STEP_MIN shrinks the step as the search closes in
	assign step_half = {1'b0, step_r[15:1]};

	// Acquisition next state; ST_TUNE clears the lock flag, and ST_START raises it and zeroes the oscillator word and divider
	always_comb
	begin
		state_nxt = state_r;
		osc_nxt = osc_r;
		step_nxt = step_r;
		div_nxt = div_r;
		lol_nxt = lol_r;
		case (state_r)
			// Restart from the bottom of the range at the fastest octave
			ST_START:
			begin
				osc_nxt = OSC_MIN;
				div_nxt = DIV_MIN_LOG;
				step_nxt = STEP_INIT;
				lol_nxt = 1'b1;
				state_nxt = ST_OCTAVE;
			end
			// Halve the sampling rate until it no longer outruns the data
			ST_OCTAVE:
				if (freq_valid)
				begin
					// Stop doubling at the widest ratio and tune there
					if (samp_faster && (div_r != DIV_MAX_LOG))
						div_nxt = div_r + 3'h1;
					else
						state_nxt = ST_TUNE;
				end
			// Climb in coarse steps, back off and halve the step on overshoot
			ST_TUNE:
				if (err_fine)
				begin
					lol_nxt = 1'b0;
					state_nxt = ST_LOCKED;
				end
				else if (freq_valid)
				begin
					// Data faster: climb; sampling faster: overshoot, so step back
					if (!samp_faster)
						osc_nxt = osc_up_sat;
					else
					begin
						osc_nxt = osc_dn_sat;
						if (step_r != STEP_MIN)
							step_nxt = step_half;
					end
				end
			// Only a large error leaves lock; small drift is left to the phase loops
			ST_LOCKED:
				if (lol_set)
				begin
					lol_nxt = 1'b1;
					state_nxt = ST_START;
				end
			default:
				state_nxt = ST_START;
		endcase
	end

	// Acquisition registers, one per process to keep each short
	// Acquisition state register
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			state_r <= ST_START;
		else
			state_r <= state_nxt;
	end

	// Oscillator word starts at the bottom of its range
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			osc_r <= OSC_MIN;
		else
			osc_r <= osc_nxt;
	end

	// Step size restarts coarse for each acquisition
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			step_r <= STEP_INIT;
		else
			step_r <= step_nxt;
	end

	// Divide ratio as a power of two
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			div_r <= DIV_MIN_LOG;
		else
			div_r <= div_nxt;
	end

	// Lock flag resets high: no rate is known until acquisition ends
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			lol_r <= 1'b1;
		else
			lol_r <= lol_nxt;
	end

	// Signal-loss hysteresis: set below threshold, release only at twice it.
	// A level between the two leaves the flag alone, which stops chatter;
	// the set test comes first so a dipping level wins over a release.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			los_r <= 1'b1;
		else if (level_below_thr)
			los_r <= 1'b1;
		else if (level_above_2thr)
			los_r <= 1'b0;
	end

	// Frequency loop runs only while unlocked; phase loops take over after
	assign osc.osc_word = osc_r;
	assign osc.div_log = div_r;
	assign osc.freq_loop_en = lol_r;

	// Flags straight from their registers, free of decode glitches
	assign loss_of_lock_flag = lol_r;
	assign signal_loss_flag = los_r;
endmodule : cdrc_ctrl

// ---- verification/cdrc_ctrl_sva.sv ----
// Checker for the acquisition and flag control ports
`timescale 1ns/1ps
module cdrc_sva
	import cdrc_pkg::*;
(
	// Clock, reset and register port
	input wire logic clock, nrst, reg_wr,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	// Detector inputs
	input wire logic freq_valid, pd_rise, pd_fall, level_below_thr,
	input wire logic [15:0] freq_err_ppm,
	input wire logic [6:0] trim_offset,
	// Outputs under watch
	input cdrc_cfg_t cfg,
	input cdrc_osc_t osc,
	input wire logic pd_up, pd_dn, loss_of_lock_flag, signal_loss_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Bandwidth field of the write data, kept as a signal for $past
	wire [2:0] wr_bw_field = reg_wdata[BW_LSB +: 3];
	// Large error while locked, then the bottom of the range
	sequence s_drift;
		!loss_of_lock_flag && freq_valid && freq_err_ppm > PPM_COARSE;
	endsequence
	sequence s_home;
		osc.osc_word == OSC_MIN && osc.div_log == DIV_MIN_LOG;
	endsequence
	// Votes from the other edge must never reach the loops
	property p_edge;
		cfg.edge_choice == EDGE_RISE && !pd_rise || cfg.edge_choice == EDGE_FALL && !pd_fall
			|-> !pd_up && !pd_dn;
	endproperty
	AST_LOL_SET: assert property (s_drift |=> loss_of_lock_flag)
		else $error("lock flag missed");
	AST_RESTART: assert property (s_drift |=> ##[0:2] s_home)
		else $error("no restart");
	AST_DIV_STEP: assert property ($changed(osc.div_log) |->
		osc.div_log == $past(osc.div_log) + 3'h1 || osc.div_log == DIV_MIN_LOG)
		else $error("divider step");
	AST_LOL_CLR: assert property ($fell(loss_of_lock_flag) |->
		$past(freq_valid) && $past(freq_err_ppm) <= PPM_FINE)
		else $error("early lock");
	AST_FLL_OFF: assert property (!loss_of_lock_flag |->
		!osc.freq_loop_en && $stable(osc.osc_word))
		else $error("frequency loop on");
	AST_EDGE: assert property (p_edge)
		else $error("edge filter");
	AST_LOS_SET: assert property (level_below_thr |=> signal_loss_flag)
		else $error("loss flag missed");
	AST_TRIM: assert property (reg_addr == ADDR_TRIM_READBACK |->
		reg_rdata == {1'b0, trim_offset})
		else $error("trim readback");
	AST_BW_WR: assert property (reg_wr && reg_addr == ADDR_EDGE_BW |=>
		cfg.bw_scale == $past(wr_bw_field))
		else $error("bandwidth write");
endmodule : cdrc_sva

// ---- verification/cdrc_src_model.sv ----
// Far-side data source as the frequency detector sees it
`timescale 1ns/1ps
module cdrc_src_model
	import cdrc_pkg::*;
(
	// Clock and oscillator state
	input wire logic clock,
	input cdrc_osc_t osc,
	// Data rate as octave and word; drift forces a large error
	input wire logic [2:0] oct,
	input wire logic [15:0] word,
	input wire logic drift,
	// Measurement
	output logic freq_valid = 1'b0,
	output logic samp_faster = 1'b0,
	output logic [15:0] freq_err_ppm = 16'h0000
);
	// One measurement a cycle, taken once the edge has settled
	always @(posedge clock)
	begin
		#1;
		freq_valid = 1'b1;
		samp_faster = osc.div_log < oct || osc.div_log == oct && osc.osc_word > word;
		freq_err_ppm = osc.osc_word > word ? osc.osc_word - word : word - osc.osc_word;
		if (drift)
			freq_err_ppm = 16'h07d0;
	end
endmodule : cdrc_src_model

// ---- verification/tb.sv ----
// Self-checking bench for the acquisition and flag control block
`timescale 1ns/1ps
module tb;
	import cdrc_pkg::*;
	// Stimulus, observed signals and tables
	logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, drift = 1'b0;
	logic level_below_thr = 1'b0, level_above_2thr = 1'b0;
	logic pd_early = 1'b0, pd_late = 1'b0, pd_rise = 1'b0, pd_fall = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [2:0] oct = 3'h2;
	logic [15:0] word = 16'h2345, freq_err_ppm;
	logic freq_valid, samp_faster, pd_up, pd_dn, loss_of_lock_flag, signal_loss_flag;
	cdrc_cfg_t cfg;
	cdrc_osc_t osc;
	int n_fail = 0, total_checks = 0, cyc = 0;
	logic [7:0] ra[5] = '{8'h10, 8'h13, 8'h14, 8'h15, 8'h73};
	logic [7:0] rv[5] = '{8'h04, 8'h06, 8'h00, 8'h00, 8'h2b};
	logic [7:0] rm[5] = '{8'h1b, 8'h03, 8'h0b, 8'hfb, 8'h2b};
	logic [7:0] sl[5] = '{8'h00, 8'h01, 8'h40, 8'h7f, 8'hc0};
	logic [1:0] lv[5] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b01};
	cdrc_ctrl i_dut (.clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .freq_valid(freq_valid),
		.samp_faster(samp_faster), .freq_err_ppm(freq_err_ppm), .pd_early(pd_early),
		.pd_late(pd_late), .pd_rise(pd_rise), .pd_fall(pd_fall),
		.level_below_thr(level_below_thr), .level_above_2thr(level_above_2thr),
		.trim_offset(7'h2b), .cfg(cfg), .osc(osc), .pd_up(pd_up), .pd_dn(pd_dn),
		.loss_of_lock_flag(loss_of_lock_flag), .signal_loss_flag(signal_loss_flag));
	cdrc_src_model i_src (.clock(clock), .osc(osc), .oct(oct), .word(word), .drift(drift),
		.freq_valid(freq_valid), .samp_faster(samp_faster), .freq_err_ppm(freq_err_ppm));
	// Free-running clock
	initial
	begin
		forever #10 clock = ~clock;
	end
	// Hang guard, far above the length of the sequence
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			test_done();
		end
	end
	task chk(input string n, input logic [19:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock) #1;
		reg_wr = 1'b0;
		@(posedge clock) #1;
	endtask : wr
	task rd(input logic [7:0] a, e);
		reg_addr = a;
		@(negedge clock) chk("rdata", reg_rdata, e);
		@(posedge clock) #1;
	endtask : rd
	task wlock(input logic v);
		for (int i = 0; i < 400 && loss_of_lock_flag !== v; i++)
			@(posedge clock) #1;
	endtask : wlock
	task test_done;
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clock);
		#1 nrst = 1'b1;
		chk("lol", loss_of_lock_flag, 1'b1);
		chk("osc", osc, 20'h00001);
		for (int i = 0; i < 5; i++)
			rd(ra[i], rv[i]);
		// Bit 2 clear keeps the adaptive slice loop off for manual codes
		for (int i = 0; i < 5; i++)
		begin
			wr(ra[i], 8'hfb);
			rd(ra[i], rm[i]);
		end
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		chk("slew", {cfg.slew, cfg.auto_slice}, 3'h6);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h15, sl[i]);
			chk("slice", {cfg.wide_slice, cfg.slice_code}, sl[i]);
		end
		wr(8'h14, 8'h08);
		chk("phase", cfg.phase_shift, 4'h8);
		// Each edge choice against a rising and a falling vote
		for (int e = 0; e < 4; e++)
		begin
			wr(8'h10, {3'h0, e[1:0], 3'h4});
			pd_early = 1'b1;
			pd_rise = 1'b1;
			@(negedge clock) chk("dn_rise", pd_dn, e != 2);
			chk("up_rise", pd_up, 1'b0);
			@(posedge clock) #1;
			pd_early = 1'b0;
			pd_late = 1'b1;
			pd_rise = 1'b0;
			pd_fall = 1'b1;
			@(negedge clock) chk("up_fall", pd_up, e != 1);
			chk("dn_fall", pd_dn, 1'b0);
			@(posedge clock) #1;
			pd_late = 1'b0;
			pd_fall = 1'b0;
		end
		// Clear at twice threshold, hold in between, set below
		for (int i = 0; i < 5; i++)
		begin
			{level_below_thr, level_above_2thr} = lv[i];
			@(posedge clock) #1;
			chk("los", signal_loss_flag, i == 2 || i == 3);
		end
		wlock(1'b0);
		chk("div", osc.div_log, oct);
		chk("fll", osc.freq_loop_en, 1'b0);
		chk("near", osc.osc_word + 16'd250 >= word && osc.osc_word <= word + 16'd250, 1'b1);
		@(negedge clock) drift = 1'b1;
		wlock(1'b1);
		chk("lost", loss_of_lock_flag, 1'b1);
		@(negedge clock) drift = 1'b0;
		oct = 3'h7;
		wlock(1'b0);
		chk("div7", osc.div_log, 3'h7);
		test_done();
	end
endmodule : tb
bind cdrc_ctrl cdrc_sva i_sva (.clock(clock), .nrst(nrst), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.freq_valid(freq_valid), .pd_rise(pd_rise), .pd_fall(pd_fall),
	.level_below_thr(level_below_thr), .freq_err_ppm(freq_err_ppm),
	.trim_offset(trim_offset), .cfg(cfg), .osc(osc), .pd_up(pd_up), .pd_dn(pd_dn),
	.loss_of_lock_flag(loss_of_lock_flag), .signal_loss_flag(signal_loss_flag));
